// [src/i2c_regport_defines.svh]
`ifndef I2C_REGPORT_DEFINES_SVH
`define I2C_REGPORT_DEFINES_SVH

// Target address after power-up
`define TGT_ADDR_DEFAULT   7'h32
// Scratch test registers
`define SCRATCH_FIRST      8'h88
`define SCRATCH_LAST       8'h8b
// Register space split: below this address is nonvolatile, at or above is RAM
`define RAM_BASE           8'h60
// Bus rates in kHz and system clock in kHz
`define STD_RATE_KHZ       100
`define FAST_RATE_KHZ      400
`define SYS_CLK_KHZ        25000
// System cycles per fast-mode bit, rounded down
`define FAST_BIT_CYCLES    (`SYS_CLK_KHZ / `FAST_RATE_KHZ)
// Bits in a byte
`define BYTE_BITS          4'h8

`endif

// [src/i2c_regport_pkg.sv]
`default_nettype none
package i2c_regport_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_ACK   = 3'b010,
		ST_WRX   = 3'b011,
		ST_RDX   = 3'b100,
		ST_RACK  = 3'b101,
		ST_SKIP  = 3'b110
	} link_state_t;

	typedef enum logic [0:0] {
		PH_POINTER = 1'b0,
		PH_DATA    = 1'b1
	} write_phase_t;
endpackage : i2c_regport_pkg
`default_nettype wire

// [src/regport_mem.sv]
`include "i2c_regport_defines.svh"
`default_nettype none
module regport_mem #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	// Clock and reset
	input  wire logic          clk_sys_i,
	input  wire logic          rst_i,
	// Write port
	input  wire logic          wr_en_i,
	input  wire logic [AW-1:0] wr_addr_i,
	input  wire logic [DW-1:0] wr_data_i,
	// Registered read port
	input  wire logic [AW-1:0] rd_addr_i,
	output logic      [DW-1:0] rd_data_o
);
	logic [DW-1:0] mem_r [0:(1<<AW)-1];

	always_ff @(posedge clk_sys_i) begin
		if (wr_en_i) begin
			mem_r[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= '0;
		end else begin
			rd_data_o <= mem_r[rd_addr_i];
		end
	end
endmodule : regport_mem
`default_nettype wire

// [src/i2c_register_access_port.sv]
// Function
// - Acts as I2C target, Standard mode to 100 kHz and Fast mode to 400 kHz.
// - Answers 7-bit target address 0x32 after reset.
// - An internal pointer selects the register; host loads it in a write first.
// - Pointer advances by one after every register read or written.
// - Pointer wraps from 0xFF to 0x00 and keeps counting.
// - Registers 0x88 to 0x8B store any written byte and read it back.
// - Reads reach nonvolatile and RAM space; writes reach RAM space only.
// - Nonvolatile space holds calibration, tracking ID, resistances, slope, intercept.
`include "i2c_regport_defines.svh"
`default_nettype none
module i2c_register_access_port #(
	parameter logic [6:0] TGT_ADDR = `TGT_ADDR_DEFAULT
) (
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	// Bus clock, input only
	input  wire logic       scl_i,
	// Bus data, open drain
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	// Factory data load port into nonvolatile space
	input  wire logic       nvm_load_i,
	input  wire logic [7:0] nvm_addr_i,
	input  wire logic [7:0] nvm_data_i,
	// Status
	output logic [7:0]      pointer_o,
	output logic            busy_o
);
	// Three-stage synchronisers
	logic [2:0] scl_sync_r;
	logic [2:0] sda_sync_r;
	logic       scl_r;
	logic       sda_r;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			scl_sync_r <= 3'h7;
			sda_sync_r <= 3'h7;
		end else begin
			scl_sync_r <= {scl_sync_r[1:0], scl_i};
			sda_sync_r <= {sda_sync_r[1:0], sda_i};
		end
	end

	// Filtered levels change only when stages two and three agree
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			scl_r <= 1'b1;
			sda_r <= 1'b1;
		end else begin
			if (scl_sync_r[1] == scl_sync_r[2]) begin
				scl_r <= scl_sync_r[2];
			end
			if (sda_sync_r[1] == sda_sync_r[2]) begin
				sda_r <= sda_sync_r[2];
			end
		end
	end

	logic scl_d_r;
	logic sda_d_r;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_r;
			sda_d_r <= sda_r;
		end
	end

	// Edge and condition detection, sampled at system rate
	wire logic scl_rise = scl_r & ~scl_d_r;
	wire logic scl_fall = ~scl_r & scl_d_r;
	wire logic start_c  = scl_r & scl_d_r & sda_d_r & ~sda_r;
	wire logic stop_c   = scl_r & scl_d_r & ~sda_d_r & sda_r;

	function automatic logic in_ram(input logic [7:0] a);
		in_ram = (a >= `RAM_BASE);
	endfunction : in_ram

	i2c_regport_pkg::link_state_t  state_r;
	i2c_regport_pkg::write_phase_t phase_r;
	logic [7:0] shift_r;
	logic [3:0] bit_cnt_r;
	logic       rw_r;
	logic [7:0] ptr_r;
	logic [7:0] ptr_nxt;
	logic       wr_en;
	logic [7:0] rd_data;
	logic       host_ack_r;

	assign ptr_nxt = ptr_r + 8'h01;

	// Writes from the bus only land in RAM space; factory port fills the rest
	assign wr_en = (state_r == i2c_regport_pkg::ST_WRX) && scl_fall
		&& (bit_cnt_r == `BYTE_BITS) && (phase_r == i2c_regport_pkg::PH_DATA)
		&& in_ram(ptr_r);

	regport_mem #(
		.AW (8),
		.DW (8)
	) u_mem (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.wr_en_i   (wr_en | nvm_load_i),
		.wr_addr_i (nvm_load_i ? nvm_addr_i : ptr_r),
		.wr_data_i (nvm_load_i ? nvm_data_i : shift_r),
		.rd_addr_i (ptr_r),
		.rd_data_o (rd_data)
	);

	// Link state machine
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_r    <= i2c_regport_pkg::ST_IDLE;
			phase_r    <= i2c_regport_pkg::PH_POINTER;
			shift_r    <= 8'h00;
			bit_cnt_r  <= 4'h0;
			rw_r       <= 1'b0;
			ptr_r      <= 8'h00;
			host_ack_r <= 1'b0;
		end else if (start_c) begin
			state_r   <= i2c_regport_pkg::ST_ADDR;
			bit_cnt_r <= 4'h0;
		end else if (stop_c) begin
			state_r <= i2c_regport_pkg::ST_IDLE;
		end else begin
			unique case (state_r)
				i2c_regport_pkg::ST_IDLE, i2c_regport_pkg::ST_SKIP: begin
				end
				i2c_regport_pkg::ST_ADDR: begin
					if (scl_rise) begin
						shift_r   <= {shift_r[6:0], sda_r};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == `BYTE_BITS) begin
						if (shift_r[7:1] == TGT_ADDR) begin
							rw_r    <= shift_r[0];
							phase_r <= i2c_regport_pkg::PH_POINTER;
							state_r <= i2c_regport_pkg::ST_ACK;
						end else begin
							state_r <= i2c_regport_pkg::ST_SKIP;
						end
					end
				end
				i2c_regport_pkg::ST_ACK: begin
					if (scl_fall) begin
						bit_cnt_r <= 4'h0;
						if (rw_r) begin
							shift_r <= rd_data;
							state_r <= i2c_regport_pkg::ST_RDX;
						end else begin
							state_r <= i2c_regport_pkg::ST_WRX;
						end
					end
				end
				i2c_regport_pkg::ST_WRX: begin
					if (scl_rise) begin
						shift_r   <= {shift_r[6:0], sda_r};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == `BYTE_BITS) begin
						if (phase_r == i2c_regport_pkg::PH_POINTER) begin
							ptr_r   <= shift_r;
							phase_r <= i2c_regport_pkg::PH_DATA;
						end else begin
							ptr_r <= ptr_nxt;
						end
						state_r <= i2c_regport_pkg::ST_ACK;
					end
				end
				i2c_regport_pkg::ST_RDX: begin
					if (scl_fall) begin
						if (bit_cnt_r == 4'h7) begin
							ptr_r   <= ptr_nxt;
							state_r <= i2c_regport_pkg::ST_RACK;
						end else begin
							shift_r   <= {shift_r[6:0], 1'b0};
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
					end
				end
				i2c_regport_pkg::ST_RACK: begin
					if (scl_rise) begin
						host_ack_r <= ~sda_r;
					end else if (scl_fall) begin
						bit_cnt_r <= 4'h0;
						if (host_ack_r) begin
							shift_r <= rd_data;
							state_r <= i2c_regport_pkg::ST_RDX;
						end else begin
							state_r <= i2c_regport_pkg::ST_SKIP;
						end
					end
				end
				default: begin
					state_r <= i2c_regport_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Data pin driver: low for ack, shift MSB while reading
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sda_o    <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
			if (state_r == i2c_regport_pkg::ST_ACK) begin
				sda_oe_o <= 1'b1;
			end else if (state_r == i2c_regport_pkg::ST_RDX) begin
				sda_oe_o <= ~shift_r[7];
			end else begin
				sda_oe_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pointer_o <= 8'h00;
			busy_o    <= 1'b0;
		end else begin
			pointer_o <= ptr_r;
			busy_o    <= (state_r != i2c_regport_pkg::ST_IDLE);
		end
	end
endmodule : i2c_register_access_port
`default_nettype wire

// [bench/i2c_regport_checker.sv]
`default_nettype none
module i2c_regport_checker (
	// Watched ports
	input wire logic       clk_sys_i,
	input wire logic       rst_i,
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_o,
	input wire logic       nvm_load_i,
	input wire logic [7:0] pointer_o,
	input wire logic       busy_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	a_sda_low_only: assert property (sda_oe_o |-> sda_o == 1'b0)
		else $error("sda driven high");
	a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("sda changed while scl high");
	a_idle_quiet: assert property (!busy_o |-> !sda_oe_o)
		else $error("sda driven while idle");
	a_ptr_busy: assert property ($changed(pointer_o) |-> busy_o || $past(busy_o))
		else $error("pointer moved outside a transfer");
	a_load_ptr: assert property (nvm_load_i && !busy_o |=> $stable(pointer_o))
		else $error("factory load moved pointer");
	a_rst_clear: assert property ($fell(rst_i) |-> pointer_o == 8'h00 && !busy_o)
		else $error("outputs not clear after reset");
	a_stop_idle: assert property ($rose(sda_i) && scl_i && $past(scl_i) |-> ##[1:10] !busy_o)
		else $error("busy after stop");
	a_start_quiet: assert property ($fell(sda_i) && scl_i && $past(scl_i) |-> !sda_oe_o [*4])
		else $error("sda driven after start");
	c_ack: cover property ($rose(sda_oe_o));
	c_wrap: cover property ($changed(pointer_o) && pointer_o == 8'h00);
	c_load: cover property (nvm_load_i && !busy_o);
endmodule : i2c_regport_checker
bind i2c_register_access_port i2c_regport_checker i_i2c_regport_checker (.clk_sys_i, .rst_i,
	.scl_i, .sda_i, .sda_o, .sda_oe_o, .nvm_load_i, .pointer_o, .busy_o);
`default_nettype wire

// [bench/i2c_host_model.sv]
`default_nettype none
module i2c_host_model (
	// Clock and wire level
	input  wire logic clk_sys_i,
	input  wire logic sda_i,
	// Host drive, sda_low_o pulls the wire down
	output logic      scl_o = 1'b1,
	output logic      sda_low_o = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	task automatic hold();
		repeat (8) @(posedge clk_sys_i);
	endtask : hold
	// Data moves only mid-way through scl low
	task automatic clk_bit(input logic b, output logic r);
		hold();
		sda_low_o <= !b;
		hold();
		scl_o <= 1'b1;
		hold();
		r = sda_i;
		scl_o <= 1'b0;
	endtask : clk_bit
	task automatic start();
		hold();
		sda_low_o <= 1'b0;
		hold();
		scl_o <= 1'b1;
		hold();
		sda_low_o <= 1'b1;
		hold();
		scl_o <= 1'b0;
	endtask : start
	task automatic stop();
		hold();
		sda_low_o <= 1'b1;
		hold();
		scl_o <= 1'b1;
		hold();
		sda_low_o <= 1'b0;
		hold();
	endtask : stop
	// Sends d MSB first, then the ninth bit; d of ff reads
	task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], q[i]);
		end
		clk_bit(last, ack);
	endtask : xbyte
endmodule : i2c_host_model
`default_nettype wire

// [bench/tb_i2c_register_access_port.sv]
`default_nettype none
module tb_i2c_register_access_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk_sys_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       nvm_load_i = 1'b0;
	logic [7:0] nvm_addr_i = 8'h00;
	logic [7:0] nvm_data_i = 8'h00;
	logic [7:0] pointer_o, q, exp_mem [256];
	logic       sda_o, sda_oe_o, busy_o, scl, host_low, ack;
	int         n_fail = 0;
	int         total_checks = 0;
	// Pulled-up open-drain wire
	wire        sda = !(host_low || (sda_oe_o && !sda_o));
	always #20 clk_sys_i = ~clk_sys_i;
	i2c_register_access_port i_i2c_register_access_port (.clk_sys_i, .rst_i, .scl_i(scl),
		.sda_i(sda), .sda_o, .sda_oe_o, .nvm_load_i, .nvm_addr_i, .nvm_data_i, .pointer_o,
		.busy_o);
	i2c_host_model i_i2c_host_model (.clk_sys_i, .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
		total_checks++;
		if (seen !== want) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask : check
	task automatic begin_at(input logic [7:0] a);
		i_i2c_host_model.start();
		i_i2c_host_model.xbyte(8'h64, 1'b1, q, ack);
		check("addr ack", 8'(ack), 8'h00);
		check("busy", 8'(busy_o), 8'h01);
		i_i2c_host_model.xbyte(a, 1'b1, q, ack);
		check("ptr ack", 8'(ack), 8'h00);
	endtask : begin_at
	task automatic wr(input logic [7:0] a, input int n, input logic [7:0] key);
		logic [7:0] p;
		p = a;
		begin_at(a);
		for (int i = 0; i < n; i++) begin
			i_i2c_host_model.xbyte(p ^ key, 1'b1, q, ack);
			check("data ack", 8'(ack), 8'h00);
			if (p >= 8'h60) exp_mem[p] = p ^ key;
			p++;
		end
		i_i2c_host_model.stop();
		check("ptr", pointer_o, p);
		check("idle", 8'(busy_o), 8'h00);
	endtask : wr
	task automatic rd(input logic [7:0] a, input int n);
		logic [7:0] p;
		p = a;
		begin_at(a);
		i_i2c_host_model.start();
		i_i2c_host_model.xbyte(8'h65, 1'b1, q, ack);
		check("read addr ack", 8'(ack), 8'h00);
		for (int i = 0; i < n; i++) begin
			i_i2c_host_model.xbyte(8'hff, i == n - 1, q, ack);
			check("read", q, exp_mem[p]);
			p++;
		end
		i_i2c_host_model.stop();
		check("ptr", pointer_o, p);
	endtask : rd
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run
	initial begin
		#2000000;
		n_fail++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys_i);
			nvm_load_i <= 1'b1;
			nvm_addr_i <= 8'(i);
			nvm_data_i <= 8'hc0 + 8'(i);
			exp_mem[i] = 8'hc0 + 8'(i);
		end
		@(posedge clk_sys_i);
		nvm_load_i <= 1'b0;
		wr(8'h88, 4, 8'h5a);
		rd(8'h88, 4);
		wr(8'h88, 4, 8'ha3);
		rd(8'h88, 4);
		// Supply cycle after the scratch readback
		@(posedge clk_sys_i);
		rst_i <= 1'b1;
		repeat (12) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		check("ptr after reset", pointer_o, 8'h00);
		check("busy after reset", 8'(busy_o), 8'h00);
		wr(8'hfe, 3, 8'h11);
		rd(8'hfe, 6);
		i_i2c_host_model.start();
		i_i2c_host_model.xbyte(8'h66, 1'b1, q, ack);
		i_i2c_host_model.stop();
		check("foreign ack", 8'(ack), 8'h01);
		complete_run();
	end
endmodule : tb_i2c_register_access_port
`default_nettype wire
